// [verilog/ilma_pkg.sv]
// shared constants and types for the interrupt line and acknowledge logic
package ilma_pkg;
  localparam int NLINE = 4;
  localparam int PRI_W = 3;
  localparam int TYPE_W = 8;
  localparam int VBASE_W = 5;
  localparam int VEC_W = 10;
  localparam int SYNC_W = 14;
  localparam int CNT_W = 7;
  // sync vector layout: lines 0..3, ready, hold, type byte
  localparam int SY_RDY = 4;
  localparam int SY_HOLD = 5;
  localparam int SY_AD_LO = 6;
  localparam int SY_AD_HI = 13;
  // fixed types of the four external lines, line n is TYPE_LINE0 + n
  localparam logic [TYPE_W-1:0] TYPE_LINE0 = 8'h0c;
  // vector address is the type times four
  localparam logic [1:0] VEC_PAD = 2'h0;
  // response time in processor clocks
  localparam logic [CNT_W-1:0] RESP_EXT_CLKS = 7'h37;
  localparam logic [CNT_W-1:0] RESP_INT_CLKS = 7'h2a;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  // bus status codes
  localparam logic [2:0] STATUS_INTA = 3'h0;
  localparam logic [2:0] STATUS_PASSIVE = 3'h7;
  // no line in service: lower than any programmed level
  localparam logic [PRI_W:0] MASK_NONE = 4'h8;
  localparam logic [TYPE_W-1:0] AD_FLOAT = 8'hff;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_C1_T1 = 4'b0001,
    ST_C1_T2 = 4'b0010,
    ST_C1_T3 = 4'b0011,
    ST_C1_T4 = 4'b0100,
    ST_GAP1 = 4'b0101,
    ST_GAP2 = 4'b0110,
    ST_C2_T1 = 4'b0111,
    ST_C2_T2 = 4'b1000,
    ST_C2_T3 = 4'b1001,
    ST_C2_T4 = 4'b1010,
    ST_FINISH = 4'b1011
  } ilma_state_t;
endpackage

// [verilog/ilma_if.sv]
// pin-level link between the integrated controller and the external controller
`timescale 1ns/100ps
interface ilma_if (
  input wire logic clk_sys
);
  import ilma_pkg::*;
  logic ext_irq0;
  logic ext_irq1;
  logic irq2_dev_o;
  logic irq2_dev_oe;
  logic irq2_ext_o;
  logic irq3_dev_o;
  logic irq3_dev_oe;
  logic irq3_ext_o;
  logic irq2_or_ack0;
  logic irq3_or_ack1;
  logic bus_lock_out;
  logic [2:0] bus_status_lines;
  logic [TYPE_W-1:0] ad_dev_o;
  logic ad_dev_oe;
  logic [TYPE_W-1:0] ad_ext_o;
  logic ad_ext_oe;
  logic [TYPE_W-1:0] ad_bus;
  logic ready;
  logic bus_hold_req;

  // wire resolution: the device wins a dual-purpose pin while it drives it
  assign irq2_or_ack0 = irq2_dev_oe ? irq2_dev_o : irq2_ext_o;
  assign irq3_or_ack1 = irq3_dev_oe ? irq3_dev_o : irq3_ext_o;
  assign ad_bus = ad_dev_oe ? ad_dev_o : (ad_ext_oe ? ad_ext_o : AD_FLOAT);

  modport dev (
    input clk_sys, ext_irq0, ext_irq1, irq2_or_ack0, irq3_or_ack1, ad_bus, ready,
    input bus_hold_req,
    output irq2_dev_o, irq2_dev_oe, irq3_dev_o, irq3_dev_oe, bus_lock_out,
    output bus_status_lines, ad_dev_o, ad_dev_oe
  );
  modport ext (
    input clk_sys, irq2_or_ack0, irq3_or_ack1, bus_lock_out, bus_status_lines, ad_bus,
    output ext_irq0, ext_irq1, irq2_ext_o, irq3_ext_o, ad_ext_o, ad_ext_oe, ready,
    output bus_hold_req
  );
endinterface

// [verilog/ilma_ext.sv]
// external controller end: cascaded or master controller and line sources
`timescale 1ns/100ps
module ilma_ext
  import ilma_pkg::*;
(
  // link
  ilma_if.ext lk,
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // requests from the sources behind this controller
  input wire logic casc_req,
  input wire logic [TYPE_W-1:0] casc_type,
  input wire logic line1_req,
  input wire logic line2_req,
  input wire logic line3_req,
  // operating choices
  input wire logic master_mode,
  input wire logic master_pick_dev,
  input wire logic ready_hold,
  input wire logic hold_req,
  // service done
  output logic served
);
  typedef struct packed {
    logic pend;
    logic pick;
    logic [1:0] acks;
    logic ack_prev;
    logic ad_oe;
    logic [TYPE_W-1:0] ad;
    logic served;
  } ilma_ext_state_t;

  ilma_ext_state_t q;
  ilma_ext_state_t n;
  logic ack_low;
  logic ack_fall;
  logic ack_rise;

  // only count pulses that come with acknowledge status, on either pair's pin
  assign ack_low = !(lk.irq2_or_ack0 && lk.irq3_or_ack1)
                   && (lk.bus_status_lines == STATUS_INTA);
  assign ack_fall = ack_low && q.ack_prev;
  assign ack_rise = !ack_low && !q.ack_prev;

  always_comb begin
    n = q;
    n.served = 1'b0;
    n.ack_prev = !ack_low;
    if (casc_req) begin
      n.pend = 1'b1;
    end
    if (ack_fall) begin
      n.acks = q.acks + 2'h1;
      if (q.acks == 2'h0) begin
        // master picks the slave when asked to and it is requesting
        n.pick = master_mode && master_pick_dev && lk.irq3_or_ack1; // R22
      end else begin
        n.ad_oe = !q.pick;
        n.ad = casc_type;
      end
    end
    // type stays on the bus until the second pulse ends
    if (ack_rise && q.acks == 2'h2) begin
      n.ad_oe = 1'b0;
      n.acks = 2'h0;
      n.pick = 1'b0;
      n.pend = casc_req; // R11
      n.served = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // request held until acknowledged; slave request is forwarded to the processor
  assign lk.ext_irq0 = q.pend || (master_mode && lk.irq3_or_ack1); // R11
  assign lk.ext_irq1 = master_mode ? q.pick : line1_req; // R21
  assign lk.irq2_ext_o = line2_req;
  assign lk.irq3_ext_o = line3_req;
  assign lk.ad_ext_o = q.ad;
  assign lk.ad_ext_oe = q.ad_oe;
  assign lk.ready = !ready_hold; // R6
  assign lk.bus_hold_req = hold_req;
  assign served = q.served;
endmodule

// [verilog/ilma_dev.sv]
// integrated controller end: line modes, arbitration and acknowledge cycles
// Function
// R1 - slave type is vector base plus level
// R2 - drive slave type only when picked
// R3 - sample pick at start of second T3
// R4 - lock both cycles, no hold grant
// R5 - two idle states between acknowledge cycles
// R6 - wait states while ready withheld
// R7 - acknowledged response takes 55 clocks
// R8 - external vectoring reads type from bus
// R9 - ack0 for line 0, ack1 for 1
// R10 - acknowledge status on status lines
// R11 - sources hold request until acknowledged
// R12 - direct mode: highest enabled request, internal vector
// R13 - per line edge or level trigger
// R14 - edge source low one clock before rearm
// R15 - cascade pairs request with acknowledge line
// R16 - pairs configured independently
// R17 - cascade accept sets in-service, blocks line
// R18 - special nested cascade ignores own in-service
// R19 - special nested direct ignores own in-service
// R20 - slave mode bit dedicates all four pins
// R21 - slave request out, pick in
// R22 - master interrupts via line 0, ack0
// R23 - internal vector is type times four
// R24 - equal levels resolved by fixed order
`timescale 1ns/100ps
module ilma_dev
  import ilma_pkg::*;
(
  // link
  ilma_if.dev lk,
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // line configuration
  input wire logic [1:0] cascade,
  input wire logic [1:0] special_nested_bit,
  input wire logic slave_mode_bit,
  input wire logic [NLINE-1:0] edge_mode,
  input wire logic [NLINE-1:0] line_en,
  input wire logic [NLINE-1:0][PRI_W-1:0] line_pri,
  input wire logic [VBASE_W-1:0] vector_base,
  // internal peripheral source used in slave mode
  input wire logic int_src_req,
  input wire logic [PRI_W-1:0] int_src_pri,
  // processor side
  output logic cpu_intr,
  input wire logic cpu_accept,
  output logic resp_valid,
  output logic [TYPE_W-1:0] resp_type,
  output logic [VEC_W-1:0] resp_vector,
  output logic resp_external,
  // in-service
  input wire logic [NLINE-1:0] is_clear,
  input wire logic int_svc_clear,
  output logic [NLINE-1:0] in_service,
  // bus hold
  output logic bus_hold_ack
);
  typedef struct packed {
    ilma_state_t st;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [NLINE-1:0] prev;
    logic [NLINE-1:0] edge_seen;
    logic [NLINE-1:0] in_svc;
    logic svc_int;
    logic [1:0] src;
    logic slave_cyc;
    logic picked;
    logic ext_vec;
    logic got_type;
    logic [CNT_W-1:0] cnt;
    logic [TYPE_W-1:0] type_q;
    logic cpu_intr;
    logic resp_valid;
    logic [TYPE_W-1:0] resp_type;
    logic [VEC_W-1:0] resp_vec;
    logic resp_ext;
    logic ack0_n;
    logic ack1_n;
    logic lock;
    logic [2:0] status;
    logic ad_oe;
    logic [TYPE_W-1:0] ad;
    logic slave_req;
    logic hold_ack;
  } ilma_dev_state_t;

  ilma_dev_state_t q;
  ilma_dev_state_t n;
  logic [NLINE-1:0] lv;
  logic [NLINE-1:0] usable;
  logic [NLINE-1:0] req;
  logic [NLINE-1:0] sfn;
  logic [NLINE-1:0] elig;
  logic [PRI_W:0] mask;
  logic [1:0] win;

  assign lv = q.sync2[NLINE-1:0];

  // per line request qualification
  genvar gi;
  generate
    for (gi = 0; gi < NLINE; gi++) begin : g_line
      // lines 2 and 3 are inputs only while their pair is not cascaded
      if (gi < 2) begin : g_lo
        assign usable[gi] = !slave_mode_bit; // R20
        assign sfn[gi] = special_nested_bit[gi];
      end else begin : g_hi
        assign usable[gi] = !slave_mode_bit && !cascade[gi-2]; // R16
        assign sfn[gi] = 1'b0;
      end
      assign req[gi] = usable[gi] && line_en[gi] && lv[gi]
                       && (!edge_mode[gi] || q.edge_seen[gi]); // R13
      // special nested lines may reenter at their own level
      assign elig[gi] = req[gi] && (sfn[gi] ? ({1'b0, line_pri[gi]} <= mask)
                                            : ({1'b0, line_pri[gi]} < mask)); // R17 R18 R19
    end
  endgenerate

  // priority mask: highest level now in service
  always_comb begin
    mask = MASK_NONE;
    for (int i = 0; i < NLINE; i++) begin
      if (q.in_svc[i] && ({1'b0, line_pri[i]} < mask)) begin
        mask = {1'b0, line_pri[i]};
      end
    end
  end

  // winner: highest level (lowest value), ties go to the lower line number
  always_comb begin
    win = 2'h0;
    for (int i = NLINE - 1; i >= 0; i--) begin
      if (elig[i] && (!elig[win] || line_pri[i] <= line_pri[win])) begin
        win = i[1:0]; // R12 R24
      end
    end
  end

  always_comb begin
    n = q;
    n.sync1 = {lk.ad_bus, lk.bus_hold_req, lk.ready, lk.irq3_or_ack1, lk.irq2_or_ack0,
               lk.ext_irq1, lk.ext_irq0};
    n.sync2 = q.sync1;
    n.prev = lv;
    n.resp_valid = 1'b0;
    // edge latch rearms only after the line has been seen low
    n.edge_seen = (q.edge_seen | (lv & ~q.prev)) & lv; // R13 R14
    // a clear in the same cycle as an accept loses to the accept
    n.in_svc = q.in_svc & ~is_clear;
    if (int_svc_clear) begin
      n.svc_int = 1'b0;
    end
    // slave request toward the master
    n.slave_req = slave_mode_bit && int_src_req && !q.svc_int; // R21
    n.cpu_intr = slave_mode_bit ? lv[0] : |elig; // R12 R22
    if (q.st != ST_IDLE && !(q.st == ST_C1_T3 || q.st == ST_C2_T3) ) begin
      n.cnt = q.cnt + CNT_ONE;
    end
    case (q.st)
      ST_IDLE: begin
        if (cpu_accept && q.cpu_intr && !q.hold_ack) begin
          n.cnt = '0;
          n.got_type = 1'b0;
          n.picked = 1'b0;
          if (slave_mode_bit) begin
            n.slave_cyc = 1'b1;
            n.src = 2'h0; // R22
            n.ext_vec = 1'b1;
            n.st = ST_C1_T1;
          end else begin
            n.slave_cyc = 1'b0;
            n.src = win;
            n.in_svc[win] = 1'b1; // R17 R18
            n.edge_seen[win] = 1'b0;
            n.ext_vec = !win[1] && cascade[win[0]]; // R8 R15
            n.type_q = TYPE_LINE0 + {6'h00, win};
            n.st = (!win[1] && cascade[win[0]]) ? ST_C1_T1 : ST_FINISH; // R12
          end
        end
      end
      ST_C1_T1: n.st = ST_C1_T2;
      ST_C1_T2: n.st = ST_C1_T3;
      ST_C1_T3: begin
        if (q.sync2[SY_RDY]) begin // R6
          n.st = ST_C1_T4;
          n.cnt = q.cnt + CNT_ONE;
        end
      end
      ST_C1_T4: n.st = ST_GAP1;
      ST_GAP1: n.st = ST_GAP2; // R5
      ST_GAP2: n.st = ST_C2_T1; // R5
      ST_C2_T1: n.st = ST_C2_T2;
      ST_C2_T2: begin
        n.st = ST_C2_T3;
        n.picked = q.slave_cyc && lv[1]; // R3
      end
      ST_C2_T3: begin
        if (q.sync2[SY_RDY]) begin // R6
          n.st = ST_C2_T4;
          n.cnt = q.cnt + CNT_ONE;
        end
      end
      ST_C2_T4: n.st = ST_FINISH;
      ST_FINISH: begin
        // bus type reaches the second sync stage one cycle after T4
        if (q.ext_vec && !q.got_type) begin
          n.got_type = 1'b1;
          n.type_q = q.picked ? {vector_base, int_src_pri}
                              : q.sync2[SY_AD_HI:SY_AD_LO]; // R1 R8
        end
        if (q.cnt >= (q.ext_vec ? RESP_EXT_CLKS : RESP_INT_CLKS) - CNT_ONE) begin // R7
          n.st = ST_IDLE;
          n.resp_valid = 1'b1;
          n.resp_type = n.type_q;
          n.resp_vec = {n.type_q, VEC_PAD}; // R23
          // a picked slave supplies its own type, so that is not external vectoring
          n.resp_ext = q.ext_vec && !q.picked; // R8
          if (q.picked) begin
            n.svc_int = 1'b1;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // pin outputs follow the next bus state
    n.lock = (n.st != ST_IDLE) && (n.st != ST_FINISH); // R4
    n.status = STATUS_PASSIVE;
    n.ack0_n = 1'b1;
    n.ack1_n = 1'b1;
    if (n.st == ST_C1_T2 || n.st == ST_C1_T3 || n.st == ST_C2_T2 || n.st == ST_C2_T3) begin
      n.status = STATUS_INTA; // R10
      n.ack0_n = n.src[0]; // R9
      n.ack1_n = !n.src[0]; // R9
    end
    n.ad = {vector_base, int_src_pri}; // R1
    n.ad_oe = n.picked && (n.st == ST_C2_T3 || n.st == ST_C2_T4); // R2
    // hold is granted only outside the locked pair
    n.hold_ack = q.sync2[SY_HOLD] && (n.st == ST_IDLE || n.st == ST_FINISH); // R4
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ack0_n <= 1'b1;
      q.ack1_n <= 1'b1;
      q.status <= STATUS_PASSIVE;
    end else begin
      q <= n;
    end
  end

  // pair pins become outputs in cascade, all are handshake pins in slave mode
  assign lk.irq2_dev_oe = slave_mode_bit || cascade[0]; // R15 R20
  assign lk.irq2_dev_o = q.ack0_n; // R22
  assign lk.irq3_dev_oe = slave_mode_bit || cascade[1]; // R15 R20
  assign lk.irq3_dev_o = slave_mode_bit ? q.slave_req : q.ack1_n; // R21
  assign lk.bus_lock_out = q.lock;
  assign lk.bus_status_lines = q.status;
  assign lk.ad_dev_o = q.ad;
  assign lk.ad_dev_oe = q.ad_oe;
  assign cpu_intr = q.cpu_intr;
  assign resp_valid = q.resp_valid;
  assign resp_type = q.resp_type;
  assign resp_vector = q.resp_vec;
  assign resp_external = q.resp_ext;
  assign in_service = q.in_svc;
  assign bus_hold_ack = q.hold_ack;
endmodule

// [test/ilma_assertions.sv]
// concurrent checks on the acknowledge handshake between the two ends
`timescale 1ns/100ps
module ilma_assertions
  import ilma_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link signals
  input wire logic irq2_or_ack0,
  input wire logic irq2_dev_oe,
  input wire logic ext_irq1,
  input wire logic ready,
  input wire logic bus_lock_out,
  input wire logic [2:0] bus_status_lines,
  input wire logic ad_dev_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire st0 = bus_status_lines == STATUS_INTA;
  wire st7 = bus_status_lines == STATUS_PASSIVE;
  logic prev_st0;
  logic second;
  // marks the second cycle so the gap check only fires after the first one
  always_ff @(posedge clk_sys) begin
    prev_st0 <= st0;
    if (rst || !bus_lock_out) second <= 1'b0;
    else if (prev_st0 && !st0) second <= !second;
  end
  property p_ack_st;
    irq2_dev_oe && !irq2_or_ack0 |-> st0;
  endproperty
  a_ack_st: assert property (p_ack_st) else $error("ack0 low without status");
  property p_st_lock;
    st0 |-> bus_lock_out;
  endproperty
  a_st_lock: assert property (p_st_lock) else $error("ack status unlocked");
  property p_idle;
    !bus_lock_out |-> st7;
  endproperty
  a_idle: assert property (p_idle) else $error("status active while idle");
  property p_rise;
    $rose(bus_lock_out) |-> st7 ##1 st0;
  endproperty
  a_rise: assert property (p_rise) else $error("first ack not after lock");
  property p_len;
    $rose(bus_lock_out) |-> bus_lock_out[*8];
  endproperty
  a_len: assert property (p_len) else $error("lock dropped early");
  property p_gap;
    prev_st0 && !st0 && !second |-> (bus_lock_out && st7)[*4] ##1 st0;
  endproperty
  a_gap: assert property (p_gap) else $error("gap between cycles wrong");
  property p_wait;
    (!ready)[*3] ##0 st0 |=> st0;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait state");
  property p_pick;
    $rose(ad_dev_oe) |-> st0 && bus_lock_out && ext_irq1;
  endproperty
  a_pick: assert property (p_pick) else $error("type driven unpicked");
  property p_ackw;
    $fell(irq2_or_ack0) && irq2_dev_oe |-> st0 ##1 (st0 && !irq2_or_ack0);
  endproperty
  a_ackw: assert property (p_ackw) else $error("ack pulse too short");
  c_lock: cover property ($rose(bus_lock_out));
  c_pick: cover property ($rose(ad_dev_oe));
  c_wait: cover property (!ready && st0);
endmodule

// [test/tb_top.sv]
// self-checking bench joining the integrated and external controller ends
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top
  import ilma_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cascade = 2'h0;
  logic [1:0] special_nested_bit = 2'h0;
  logic slave_mode_bit = 1'b0;
  logic [NLINE-1:0] edge_mode = 4'h0;
  logic [NLINE-1:0][PRI_W-1:0] line_pri = '0;
  logic int_src_req = 1'b0;
  logic cpu_accept = 1'b0;
  logic [NLINE-1:0] is_clear = 4'h0;
  logic int_svc_clear = 1'b0;
  logic casc_req = 1'b0;
  logic line2_req = 1'b0;
  logic line3_req = 1'b0;
  logic line1_req = 1'b0;
  logic [NLINE-1:0] line_en = 4'hf;
  logic master_mode = 1'b0;
  logic master_pick_dev = 1'b0;
  logic ready_hold = 1'b0;
  logic hold_req = 1'b0;
  logic cpu_intr, resp_valid, resp_external, bus_hold_ack, a0, a1, doe, served;
  logic [TYPE_W-1:0] resp_type;
  logic [VEC_W-1:0] resp_vector;
  logic [NLINE-1:0] in_service;
  int failures = 0;
  int tests_run = 0;
  int n_ack0, n_ack1, n_doe, n_lock, hold_bad, n_served;

  ilma_if lk (.clk_sys(clk_sys));
  ilma_dev u_ilma_dev (.lk(lk.dev), .clk_sys(clk_sys), .rst(rst), .cascade(cascade),
    .special_nested_bit(special_nested_bit), .slave_mode_bit(slave_mode_bit),
    .edge_mode(edge_mode), .line_en(line_en), .line_pri(line_pri), .vector_base(5'h13),
    .int_src_req(int_src_req), .int_src_pri(3'h5), .cpu_intr(cpu_intr),
    .cpu_accept(cpu_accept), .resp_valid(resp_valid), .resp_type(resp_type),
    .resp_vector(resp_vector), .resp_external(resp_external), .is_clear(is_clear),
    .int_svc_clear(int_svc_clear), .in_service(in_service), .bus_hold_ack(bus_hold_ack));
  ilma_ext u_ilma_ext (.lk(lk.ext), .clk_sys(clk_sys), .rst(rst), .casc_req(casc_req),
    .casc_type(8'h5a), .line1_req(line1_req), .line2_req(line2_req), .line3_req(line3_req),
    .master_mode(master_mode), .master_pick_dev(master_pick_dev),
    .ready_hold(ready_hold), .hold_req(hold_req), .served(served));
  ilma_assertions u_ilma_assertions (.clk_sys(clk_sys), .rst(rst),
    .irq2_or_ack0(lk.irq2_or_ack0), .irq2_dev_oe(lk.irq2_dev_oe), .ext_irq1(lk.ext_irq1),
    .ready(lk.ready), .bus_lock_out(lk.bus_lock_out),
    .bus_status_lines(lk.bus_status_lines), .ad_dev_oe(lk.ad_dev_oe));

  initial forever #25 clk_sys = ~clk_sys;

  // edge and cycle counters on the link pins, hold grant and served pulse
  always @(posedge clk_sys) begin
    a0 <= lk.irq2_or_ack0;
    a1 <= lk.irq3_or_ack1;
    doe <= lk.ad_dev_oe;
    if (a0 && !lk.irq2_or_ack0 && lk.irq2_dev_oe) n_ack0++;
    if (a1 && !lk.irq3_or_ack1 && lk.irq3_dev_oe) n_ack1++;
    if (!doe && lk.ad_dev_oe) n_doe++;
    if (lk.bus_lock_out) n_lock++;
    if (lk.bus_lock_out && bus_hold_ack) hold_bad++;
    if (served) n_served++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic zero;
    n_ack0 = 0;
    n_ack1 = 0;
    n_doe = 0;
    n_lock = 0;
    hold_bad = 0;
    n_served = 0;
  endtask
  task automatic clr(input logic [NLINE-1:0] m);
    is_clear <= m;
    cyc(1);
    is_clear <= 4'h0;
  endtask
  task automatic casc;
    casc_req <= 1'b1;
    cyc(1);
    casc_req <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // lat 0 means wait states expected, so only a lower bound is known
  task automatic run(input logic [TYPE_W-1:0] typ, input logic ext, input int lat);
    int n;
    n = 0;
    while (cpu_intr !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    // no request in time: nothing accepted, so the response wait below fails
    if (cpu_intr === 1'b1) cpu_accept <= 1'b1;
    cyc(1);
    cpu_accept <= 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    if (resp_valid !== 1'b1) begin
      failures++;
      wrap_up();
    end else begin
      if (lat > 0) `CHK(n, lat + 1)
      else `CHK(n > 56, 1'b1)
      `CHK(resp_type, typ)
      `CHK(resp_external, ext)
      `CHK(resp_vector, {typ, VEC_PAD})
    end
  endtask

  initial begin
    zero;
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    // equal levels on two direct lines: lower index first, same level then blocked
    line2_req <= 1'b1;
    line3_req <= 1'b1;
    run(8'h0e, 1'b0, 42);
    `CHK(in_service, 4'h4)
    cyc(6);
    `CHK(cpu_intr, 1'b0)
    line2_req <= 1'b0;
    cyc(4);
    clr(4'h4);
    run(8'h0f, 1'b0, 42);
    `CHK(n_lock, 0)
    // edge mode needs a fresh low-to-high transition
    edge_mode <= 4'h8;
    clr(4'h8);
    cyc(6);
    `CHK(cpu_intr, 1'b0)
    line3_req <= 1'b0;
    cyc(2);
    line3_req <= 1'b1;
    run(8'h0f, 1'b0, 42);
    line3_req <= 1'b0;
    edge_mode <= 4'h0;
    cyc(4);
    clr(4'h8);
    // special nested direct line 0 re-enters at its own level; request stays pending
    special_nested_bit <= 2'h1;
    casc;
    run(TYPE_LINE0, 1'b0, 42);
    cyc(6);
    `CHK(cpu_intr, 1'b1)
    special_nested_bit <= 2'h0;
    clr(4'h1);
    // cascade pair 0, hold raised while locked
    cascade <= 2'h1;
    cyc(2);
    zero;
    casc;
    fork
      run(8'h5a, 1'b1, 55);
      begin
        cyc(3);
        hold_req <= 1'b1;
      end
    join
    `CHK(n_ack0, 2)
    `CHK(n_ack1, 0)
    `CHK(n_served, 1)
    `CHK(hold_bad, 0)
    `CHK(bus_hold_ack, 1'b1)
    `CHK(in_service, 4'h1)
    hold_req <= 1'b0;
    cyc(4);
    casc;
    cyc(8);
    `CHK(cpu_intr, 1'b0)
    special_nested_bit <= 2'h1;
    run(8'h5a, 1'b1, 55);
    special_nested_bit <= 2'h0;
    clr(4'h1);
    // pair 1 stays direct while pair 0 is cascaded; disabled line is ignored
    line_en <= 4'h7;
    line3_req <= 1'b1;
    cyc(6);
    `CHK(cpu_intr, 1'b0)
    line_en <= 4'hf;
    run(8'h0f, 1'b0, 42);
    line3_req <= 1'b0;
    cyc(4);
    clr(4'h8);
    // ready withheld stretches the acknowledge cycle
    ready_hold <= 1'b1;
    casc;
    fork
      run(8'h5a, 1'b1, 0);
      begin
        cyc(30);
        ready_hold <= 1'b0;
      end
    join
    clr(4'h1);
    // pair 1 cascaded alone, acknowledged on its own pin
    cascade <= 2'h2;
    line1_req <= 1'b1;
    zero;
    run(8'h5a, 1'b1, 55);
    line1_req <= 1'b0;
    `CHK(n_ack1, 2)
    `CHK(n_ack0, 0)
    `CHK(in_service, 4'h2)
    clr(4'h2);
    // slave mode, picked then not picked
    cascade <= 2'h0;
    slave_mode_bit <= 1'b1;
    master_mode <= 1'b1;
    master_pick_dev <= 1'b1;
    int_src_req <= 1'b1;
    cyc(4);
    `CHK(lk.irq3_or_ack1, 1'b1)
    zero;
    run(8'h9d, 1'b0, 55);
    `CHK(n_ack0, 2)
    `CHK(n_doe, 1)
    master_pick_dev <= 1'b0;
    int_svc_clear <= 1'b1;
    cyc(1);
    int_svc_clear <= 1'b0;
    zero;
    run(8'h5a, 1'b1, 55);
    `CHK(n_doe, 0)
    wrap_up();
  end
endmodule
